// file: core/aaf_cfg.svh
// Constants for the converter alarm flag register bank.
// Assumes a single clock domain and a serial front end that decodes
// register addresses and strobes reads on the same clock.
//
// Function
// R1: Each channel has a high and a low threshold, each with its own active and tripped flag.
// R2: An active flag is 1 while its alarm condition holds and returns to 0 when it ends.
// R3: A tripped flag sets like its active flag and stays 1 until its register is read.
// R4: Address 11h holds tripped flags of channels 0-3, bit 7 ch0 low down to bit 0 ch3 high.
// R5: Address 12h holds active flags of channels 0-3 in the same low/high pair order.
// R6: Address 13h holds tripped flags of channels 4-7, bit 7 ch4 low down to bit 0 ch7 high.
// R7: Address 14h holds active flags of channels 4-7 in the same low/high pair order.
// R8: A flag bit reads 0 when no alarm was detected and 1 when one was.
// R9: The four flag registers are read-only and every flag resets to 0.
// R10: In the four-channel build a write to 13h or 14h changes nothing.
// R11: In the four-channel build a read of 13h or 14h returns all ones.
// R12: Alarm events show on the alarm output so the host knows to read the flags.
// R13: Comparisons use a 16-bit threshold and an 8-bit hysteresis shared by high and low.
// R14: A tripped flag clears once the read of its register completes, and sets again if the alarm persists.
`ifndef AAF_CFG_SVH
`define AAF_CFG_SVH

// ==========================================================
// Register offsets
`define AAF_ADDR_W 8
`define AAF_ADDR_TRIP_LO 8'h11
`define AAF_ADDR_ACT_LO 8'h12
`define AAF_ADDR_TRIP_HI 8'h13
`define AAF_ADDR_ACT_HI 8'h14

// ==========================================================
// Field layout and values
`define AAF_REG_W 8
`define AAF_GRP_CH 4
`define AAF_MAX_CH 8
`define AAF_FLAG_RST 8'h00
`define AAF_ABSENT_DATA 8'hff
`define AAF_UNMAPPED_DATA 8'h00

// ==========================================================
// Comparison widths
`define AAF_DATA_W 16
`define AAF_HYST_W 8

`endif

// file: core/aaf_pkg.sv
// Types shared by the alarm flag register bank.
// Assumes the constants header is compiled alongside.
package aaf_pkg;

  // ==========================================================
  // Read sequencer states, one-hot
  typedef enum logic [2:0] {
    AAF_ST_IDLE = 3'b001,
    AAF_ST_SHIFT = 3'b010,
    AAF_ST_CLEAR = 3'b100
  } aaf_state_t;

  // ==========================================================
  // Which tripped group a completed read clears
  typedef enum logic [1:0] {
    AAF_CLR_NONE = 2'h0,
    AAF_CLR_GRP0 = 2'h1,
    AAF_CLR_GRP1 = 2'h2
  } aaf_clr_t;

endpackage : aaf_pkg

// file: core/aaf_chan_cmp.sv
// One channel's high and low alarm comparators with hysteresis.
// Assumes eval_i pulses once per conversion result of this channel,
// with data and thresholds stable in that cycle.
module aaf_chan_cmp #(
  parameter int DATA_W = 16,
  parameter int HYST_W = 8
) (
  input wire logic mclk_i,                 // System clock
  input wire logic rst_i,                  // Async reset, high
  input wire logic eval_i,                 // New result for channel
  input wire logic [DATA_W-1:0] data_i,    // Conversion result
  input wire logic [DATA_W-1:0] hi_thr_i,  // High threshold
  input wire logic [DATA_W-1:0] lo_thr_i,  // Low threshold
  input wire logic [HYST_W-1:0] hyst_i,    // Shared hysteresis
  output logic hi_act_o,                   // High alarm active
  output logic lo_act_o,                   // Low alarm active
  output logic hi_hit_o,                   // High alarm seen, pulse
  output logic lo_hit_o                    // Low alarm seen, pulse
);

  logic hi_q, hi_d;
  logic lo_q, lo_d;
  logic [DATA_W:0] data_ext;
  logic [DATA_W:0] data_up;
  logic [DATA_W:0] lo_up;
  logic hi_cond;
  logic lo_cond;

  // ==========================================================
  // Condition with hysteresis
  // R13 16-bit thresholds, shared hysteresis
  assign data_ext = {1'b0, data_i};
  assign data_up = data_ext + {{(DATA_W + 1 - HYST_W){1'b0}}, hyst_i};
  assign lo_up = {1'b0, lo_thr_i} + {{(DATA_W + 1 - HYST_W){1'b0}}, hyst_i};

  // High sets above threshold, holds until below it minus hysteresis; low sets below, holds until above it plus hysteresis
  always_comb begin
    if (hi_q) begin
      hi_cond = data_up >= {1'b0, hi_thr_i};
    end else begin
      hi_cond = data_i > hi_thr_i;
    end
    if (lo_q) begin
      lo_cond = data_ext <= lo_up;
    end else begin
      lo_cond = data_i < lo_thr_i;
    end
  end

  // ==========================================================
  // Active flags
  // R2 follow condition each result
  always_comb begin
    hi_d = hi_q;
    lo_d = lo_q;
    if (eval_i) begin
      hi_d = hi_cond;
      lo_d = lo_cond;
    end
  end

  // R9 flags reset to zero
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      hi_q <= 1'b0;
      lo_q <= 1'b0;
    end else begin
      hi_q <= hi_d;
      lo_q <= lo_d;
    end
  end

  assign hi_act_o = hi_q;
  assign lo_act_o = lo_q;
  // R3 trip on same condition
  assign hi_hit_o = eval_i & hi_cond;
  assign lo_hit_o = eval_i & lo_cond;

endmodule : aaf_chan_cmp

// file: core/aaf_flag_regs.sv
// Alarm flag register bank for an eight- or four-channel converter.
// Assumes the serial front end on the same clock presents a register
// address with a one-cycle read or write request, and pulses read
// done once the answer byte has been shifted out. Conversion results
// arrive from the datapath on the same clock, one channel at a time.
`include "aaf_cfg.svh"

module aaf_flag_regs #(
  parameter int NUM_CH = 8,   // 8 or 4 channel build
  parameter int DATA_W = 16,  // Result and threshold width
  parameter int HYST_W = 8    // Hysteresis width
) (
  input wire logic mclk_i,                           // System clock
  input wire logic rst_i,                            // Async reset, high
  input wire logic res_valid_i,                      // Result strobe
  input wire logic [2:0] res_chan_i,                 // Result channel
  input wire logic [DATA_W-1:0] res_data_i,          // Result value
  input wire logic [NUM_CH*DATA_W-1:0] hi_thr_i,     // High thresholds
  input wire logic [NUM_CH*DATA_W-1:0] lo_thr_i,     // Low thresholds
  input wire logic [NUM_CH*HYST_W-1:0] hyst_i,       // Hysteresis values
  input wire logic rd_req_i,                         // Register read request
  input wire logic wr_req_i,                         // Register write request
  input wire logic [`AAF_ADDR_W-1:0] addr_i,         // Register address
  input wire logic rd_done_i,                        // Read byte shifted out
  output logic [`AAF_REG_W-1:0] rd_data_o,           // Read data
  output logic rd_busy_o,                            // Read in progress
  output logic alarm_o                               // Alarm pin level
);

  localparam int GRP = `AAF_GRP_CH;
  localparam int MAXC = `AAF_MAX_CH;

  // ==========================================================
  // Declarations
  aaf_pkg::aaf_state_t state_q, state_d;
  aaf_pkg::aaf_clr_t clr_q, clr_d;
  logic [`AAF_REG_W-1:0] rd_data_q, rd_data_d;
  logic [MAXC-1:0] act_hi;
  logic [MAXC-1:0] act_lo;
  logic [MAXC-1:0] hit_hi;
  logic [MAXC-1:0] hit_lo;
  logic [MAXC-1:0] trip_hi_q, trip_hi_d;
  logic [MAXC-1:0] trip_lo_q, trip_lo_d;
  logic [MAXC-1:0] clr_hi_mask;
  logic [MAXC-1:0] clr_lo_mask;
  logic alarm_q, alarm_d;
  logic is_upper;
  logic upper_absent;
  logic [`AAF_REG_W-1:0] reg_trip0;
  logic [`AAF_REG_W-1:0] reg_act0;
  logic [`AAF_REG_W-1:0] reg_trip1;
  logic [`AAF_REG_W-1:0] reg_act1;

  // ==========================================================
  // Pack four channels into low/high pairs, channel 0 of the group on top
  function automatic logic [`AAF_REG_W-1:0] pack_pairs(
    input logic [GRP-1:0] lo,
    input logic [GRP-1:0] hi
  );
    logic [`AAF_REG_W-1:0] r;
    r = `AAF_FLAG_RST;
    for (int i = 0; i < GRP; i++) begin
      r[`AAF_REG_W - 1 - 2 * i] = lo[i];
      r[`AAF_REG_W - 2 - 2 * i] = hi[i];
    end
    return r;
  endfunction : pack_pairs

  // ==========================================================
  // Per-channel comparators
  // R1 two thresholds per channel
  for (genvar g = 0; g < MAXC; g++) begin : g_ch
    if (g < NUM_CH) begin : g_on
      aaf_chan_cmp #(
        .DATA_W(DATA_W),
        .HYST_W(HYST_W)
      ) u_cmp (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .eval_i(res_valid_i && (res_chan_i == 3'(g))),
        .data_i(res_data_i),
        .hi_thr_i(hi_thr_i[g*DATA_W +: DATA_W]),
        .lo_thr_i(lo_thr_i[g*DATA_W +: DATA_W]),
        .hyst_i(hyst_i[g*HYST_W +: HYST_W]),
        .hi_act_o(act_hi[g]),
        .lo_act_o(act_lo[g]),
        .hi_hit_o(hit_hi[g]),
        .lo_hit_o(hit_lo[g])
      );
    end else begin : g_off
      // Absent channel never alarms
      assign act_hi[g] = 1'b0;
      assign act_lo[g] = 1'b0;
      assign hit_hi[g] = 1'b0;
      assign hit_lo[g] = 1'b0;
    end
  end

  // ==========================================================
  // Register images
  // R4 tripped ch0-3 at 11h
  assign reg_trip0 = pack_pairs(trip_lo_q[GRP-1:0], trip_hi_q[GRP-1:0]);
  // R5 active ch0-3 at 12h
  assign reg_act0 = pack_pairs(act_lo[GRP-1:0], act_hi[GRP-1:0]);
  // R6 tripped ch4-7 at 13h
  assign reg_trip1 = pack_pairs(trip_lo_q[MAXC-1:GRP], trip_hi_q[MAXC-1:GRP]);
  // R7 active ch4-7 at 14h
  assign reg_act1 = pack_pairs(act_lo[MAXC-1:GRP], act_hi[MAXC-1:GRP]);

  // Upper group decode and presence
  assign is_upper = (addr_i == `AAF_ADDR_TRIP_HI) || (addr_i == `AAF_ADDR_ACT_HI);
  assign upper_absent = (NUM_CH <= GRP);

  // ==========================================================
  // Read sequencer: capture, wait for shift-out, then clear
  always_comb begin
    state_d = state_q;
    clr_d = clr_q;
    rd_data_d = rd_data_q;
    case (state_q)
      aaf_pkg::AAF_ST_IDLE: begin
        if (rd_req_i) begin
          state_d = aaf_pkg::AAF_ST_SHIFT;
          clr_d = aaf_pkg::AAF_CLR_NONE;
          // R8 flag bits read as stored
          case (addr_i)
            `AAF_ADDR_TRIP_LO: begin
              rd_data_d = reg_trip0;
              clr_d = aaf_pkg::AAF_CLR_GRP0;
            end
            `AAF_ADDR_ACT_LO: begin
              rd_data_d = reg_act0;
            end
            `AAF_ADDR_TRIP_HI: begin
              rd_data_d = reg_trip1;
              clr_d = aaf_pkg::AAF_CLR_GRP1;
            end
            `AAF_ADDR_ACT_HI: begin
              rd_data_d = reg_act1;
            end
            default: begin
              rd_data_d = `AAF_UNMAPPED_DATA;
            end
          endcase
          // R11 absent registers read ones
          if (is_upper && upper_absent) begin
            rd_data_d = `AAF_ABSENT_DATA;
            clr_d = aaf_pkg::AAF_CLR_NONE;
          end
        end else if (wr_req_i) begin
          // R9 writes do not store
          // R10 absent registers ignore writes
          state_d = aaf_pkg::AAF_ST_IDLE;
        end
      end
      aaf_pkg::AAF_ST_SHIFT: begin
        if (rd_done_i) begin
          state_d = aaf_pkg::AAF_ST_CLEAR;
        end
      end
      aaf_pkg::AAF_ST_CLEAR: begin
        state_d = aaf_pkg::AAF_ST_IDLE;
        clr_d = aaf_pkg::AAF_CLR_NONE;
      end
      default: begin
        state_d = aaf_pkg::AAF_ST_IDLE;
        clr_d = aaf_pkg::AAF_CLR_NONE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= aaf_pkg::AAF_ST_IDLE;
      clr_q <= aaf_pkg::AAF_CLR_NONE;
      rd_data_q <= `AAF_FLAG_RST;
    end else begin
      state_q <= state_d;
      clr_q <= clr_d;
      rd_data_q <= rd_data_d;
    end
  end

  // ==========================================================
  // Clear only the tripped bits the host was shown, so a hit that
  // lands while the byte shifts out survives for the next read
  always_comb begin
    clr_hi_mask = '0;
    clr_lo_mask = '0;
    if (state_q == aaf_pkg::AAF_ST_CLEAR) begin
      for (int i = 0; i < GRP; i++) begin
        case (clr_q)
          aaf_pkg::AAF_CLR_GRP0: begin
            clr_lo_mask[i] = rd_data_q[`AAF_REG_W - 1 - 2 * i];
            clr_hi_mask[i] = rd_data_q[`AAF_REG_W - 2 - 2 * i];
          end
          aaf_pkg::AAF_CLR_GRP1: begin
            clr_lo_mask[GRP + i] = rd_data_q[`AAF_REG_W - 1 - 2 * i];
            clr_hi_mask[GRP + i] = rd_data_q[`AAF_REG_W - 2 - 2 * i];
          end
          default: begin
            clr_lo_mask[i] = 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Tripped flags, set wins over a clear in the same cycle
  always_comb begin
    // R14 clear after read completes
    trip_hi_d = trip_hi_q & ~clr_hi_mask;
    trip_lo_d = trip_lo_q & ~clr_lo_mask;
    // R3 latch on alarm
    trip_hi_d = trip_hi_d | hit_hi;
    trip_lo_d = trip_lo_d | hit_lo;
  end

  // R9 tripped flags reset to zero
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      trip_hi_q <= '0;
      trip_lo_q <= '0;
    end else begin
      trip_hi_q <= trip_hi_d;
      trip_lo_q <= trip_lo_d;
    end
  end

  // ==========================================================
  // Alarm pin: any tripped flag pending
  always_comb begin
    // R12 alarm output on events
    alarm_d = |{trip_hi_d, trip_lo_d};
  end

  // Alarm pin register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      alarm_q <= 1'b0;
    end else begin
      alarm_q <= alarm_d;
    end
  end

  // ==========================================================
  // Outputs
  assign rd_data_o = rd_data_q;   // Held until next read
  assign rd_busy_o = (state_q != aaf_pkg::AAF_ST_IDLE);
  assign alarm_o = alarm_q;

endmodule : aaf_flag_regs

// file: tb/aaf_flag_regs_chk.sv
// Port checker for the alarm flag register bank.
// Assumes one clock and async high reset; bound to every bank.
module aaf_flag_chk #(
  parameter int NUM_CH = 8,
  parameter int DATA_W = 16
) (
  input wire logic mclk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic res_valid_i, // Result strobe
  input wire logic [2:0] res_chan_i, // Channel
  input wire logic [DATA_W-1:0] res_data_i, // Result
  input wire logic [NUM_CH*DATA_W-1:0] hi_thr_i, // High limits
  input wire logic [NUM_CH*DATA_W-1:0] lo_thr_i, // Low limits
  input wire logic rd_req_i, // Read
  input wire logic wr_req_i, // Write
  input wire logic [7:0] addr_i, // Address
  input wire logic rd_done_i, // Byte out
  input wire logic [7:0] rd_data_o, // Read data
  input wire logic rd_busy_o, // Busy
  input wire logic alarm_o // Alarm pin
);
  logic take;
  logic [DATA_W-1:0] ht;
  logic [DATA_W-1:0] lt;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  // Accepted read and this result's limits
  assign take = rd_req_i && !rd_busy_o;
  assign ht = hi_thr_i[res_chan_i*DATA_W+:DATA_W];
  assign lt = lo_thr_i[res_chan_i*DATA_W+:DATA_W];
  // ====
  // Read sequence
  a_busy_rise: assert property (take |=> rd_busy_o)
    else $error("busy low after read");
  a_unmapped_zero: assert property (
    take && !(addr_i inside {[8'h11:8'h14]}) |=> rd_data_o == 8'h00)
    else $error("unmapped read not zero");
  a_clear_seq: assert property (rd_done_i && rd_busy_o |=> rd_busy_o ##1 !rd_busy_o)
    else $error("clear cycle wrong");
  a_data_hold: assert property (!take |=> $stable(rd_data_o))
    else $error("read data moved");
  a_write_none: assert property (wr_req_i && !rd_req_i && !rd_busy_o |=> !rd_busy_o)
    else $error("write started a read");
  // ====
  // Alarm flags
  a_high_trip: assert property (
    res_valid_i && res_chan_i < NUM_CH && res_data_i > ht |=> alarm_o)
    else $error("high cross not flagged");
  a_low_trip: assert property (
    res_valid_i && res_chan_i < NUM_CH && res_data_i < lt |=> alarm_o)
    else $error("low cross not flagged");
  a_alarm_hold: assert property (alarm_o && !rd_busy_o |=> alarm_o)
    else $error("alarm dropped without read");
  a_alarm_cause: assert property ($rose(alarm_o) |-> $past(res_valid_i))
    else $error("alarm rose without result");
endmodule : aaf_flag_chk

bind aaf_flag_regs aaf_flag_chk #(.NUM_CH(NUM_CH), .DATA_W(DATA_W)) i_chk (
  .mclk_i(mclk_i), .rst_i(rst_i), .res_valid_i(res_valid_i), .res_chan_i(res_chan_i),
  .res_data_i(res_data_i), .hi_thr_i(hi_thr_i), .lo_thr_i(lo_thr_i), .rd_req_i(rd_req_i),
  .wr_req_i(wr_req_i), .addr_i(addr_i), .rd_done_i(rd_done_i), .rd_data_o(rd_data_o),
  .rd_busy_o(rd_busy_o), .alarm_o(alarm_o)
);

// file: tb/aaf_host_mdl.sv
// Serial host model that reads and writes the flag registers.
// Assumes the bank raises busy one cycle after a taken read.
module aaf_host_mdl (
  input wire logic mclk_i, // Clock
  input wire logic busy_i, // Bank busy
  output logic rd_req_o, // Read pulse
  output logic wr_req_o, // Write pulse
  output logic [7:0] addr_o, // Address
  output logic rd_done_o // Byte out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    rd_req_o = 1'b0;
    wr_req_o = 1'b0;
    addr_o = 8'h00;
    rd_done_o = 1'b0;
  end
  // ====
  // Read, shift delay, done pulse, bounded wait for idle
  // read completes
  task automatic rd(input logic [7:0] a, input int slow, output bit ok);
    @(posedge mclk_i);
    #1;
    rd_req_o = 1'b1;
    addr_o = a;
    @(posedge mclk_i);
    #1;
    rd_req_o = 1'b0;
    addr_o = ~a;
    repeat (slow) begin
      @(posedge mclk_i);
      #1;
    end
    rd_done_o = 1'b1;
    @(posedge mclk_i);
    #1;
    rd_done_o = 1'b0;
    for (int n = 0; n < 4 && busy_i; n++) begin
      @(posedge mclk_i);
      #1;
    end
    ok = !busy_i;
  endtask : rd
  // Write pulse
  task automatic wr(input logic [7:0] a);
    @(posedge mclk_i);
    #1;
    wr_req_o = 1'b1;
    addr_o = a;
    @(posedge mclk_i);
    #1;
    wr_req_o = 1'b0;
    addr_o = ~a;
  endtask : wr
endmodule : aaf_host_mdl

// file: tb/tb_top.sv
// Self-checking bench for the 8- and 4-channel flag banks.
// Assumes design, checker and host model are compiled first.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_i, rst_i, res_valid, rq, wq, dn, busy, busy_q, alarm;
  logic [2:0] res_chan;
  logic [15:0] res_data;
  logic [7:0] addr, rdat, rdat4;
  logic [15:0] exq[$];
  int fails, num_checks;
  // ====
  // Clock, both builds and host
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  aaf_flag_regs i_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .res_valid_i(res_valid), .res_chan_i(res_chan),
    .res_data_i(res_data), .hi_thr_i({8{16'h8000}}), .lo_thr_i({8{16'h1000}}),
    .hyst_i({8{8'h10}}), .rd_req_i(rq), .wr_req_i(wq), .addr_i(addr), .rd_done_i(dn),
    .rd_data_o(rdat), .rd_busy_o(busy), .alarm_o(alarm)
  );
  aaf_flag_regs #(.NUM_CH(4)) i_dut4 (
    .mclk_i(mclk_i), .rst_i(rst_i), .res_valid_i(res_valid), .res_chan_i(res_chan),
    .res_data_i(res_data), .hi_thr_i({4{16'h8000}}), .lo_thr_i({4{16'h1000}}),
    .hyst_i({4{8'h10}}), .rd_req_i(rq), .wr_req_i(wq), .addr_i(addr), .rd_done_i(dn),
    .rd_data_o(rdat4), .rd_busy_o(), .alarm_o()
  );
  aaf_host_mdl i_host (
    .mclk_i(mclk_i), .busy_i(busy), .rd_req_o(rq), .wr_req_o(wq), .addr_o(addr),
    .rd_done_o(dn)
  );
  // ====
  // Compare, verdict, stimulus tasks
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    num_checks++;
    if (got !== ex) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic end_of_test();
    if (exq.size() != 0) begin
      fails++;
      $display("unexpected pending reads: expected 0, seen %0d", exq.size());
    end
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  task automatic res(input int ch, input logic [15:0] d);
    @(posedge mclk_i);
    #1;
    res_valid = 1'b1;
    res_chan = ch[2:0];
    res_data = d;
    @(posedge mclk_i);
    #1;
    res_valid = 1'b0;
    res_data = ~d;
  endtask : res
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    bit ok;
    exq.push_back({a, e});
    i_host.rd(a, $urandom % 4, ok);
    if (!ok) begin
      fails++;
      $display("unexpected busy after read %h: expected 0, seen 1", a);
      end_of_test();
    end
  endtask : rdx
  // Watcher: fresh read byte against the oldest note
  always @(posedge mclk_i) begin
    logic [15:0] e;
    busy_q <= busy;
    if (busy === 1'b1 && busy_q === 1'b0) begin
      e = (exq.size() > 0) ? exq.pop_front() : 16'hxxxx;
      chk("read byte", e[7:0], rdat);
      if (e[15:8] == 8'h13 || e[15:8] == 8'h14) begin
        chk("four channel byte", 8'hff, rdat4);
      end
    end
  end
  // ====
  // Main sequence
  initial begin
    int ch;
    int lo;
    rst_i = 1'b1;
    res_valid = 1'b0;
    res_chan = 3'h0;
    res_data = 16'h0000;
    fails = 0;
    num_checks = 0;
    void'($urandom(32'h3c49));
    repeat (5) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    // Reset values and unmapped neighbours
    chk("alarm", 8'h00, {7'h00, alarm});
    for (int a = 16; a <= 21; a++) begin
      rdx(a[7:0], 8'h00);
    end
    $display("test reset done");
    // Active follows the condition, tripped latches until read
    res(2, 16'hc000);
    chk("alarm", 8'h01, {7'h00, alarm});
    res(2, 16'h7ff8);
    rdx(8'h12, 8'h04);
    res(2, 16'h4000);
    rdx(8'h12, 8'h00);
    rdx(8'h11, 8'h04);
    rdx(8'h11, 8'h00);
    chk("alarm", 8'h00, {7'h00, alarm});
    $display("test latch done");
    // A hit taken with a read stays latched for the next read
    fork
      rdx(8'h11, 8'h00);
      res(2, 16'hc000);
    join
    rdx(8'h11, 8'h04);
    res(2, 16'h4000);
    rdx(8'h11, 8'h00);
    $display("test overlap done");
    // Bit placement for random channels and limits
    for (int i = 0; i < 10; i++) begin
      ch = $urandom % 8;
      lo = $urandom % 2;
      res(ch, (lo == 1) ? 16'h0100 : 16'hc000);
      rdx((ch < 4) ? 8'h12 : 8'h14, 8'h01 << (7 - 2 * (ch % 4) - (lo == 0)));
      res(ch, 16'h4000);
      rdx((ch < 4) ? 8'h11 : 8'h13, 8'h01 << (7 - 2 * (ch % 4) - (lo == 0)));
    end
    $display("test mapping done");
    // Writes to the upper group change nothing
    res(5, 16'h0100);
    i_host.wr(8'h13);
    i_host.wr(8'h14);
    rdx(8'h14, 8'h20);
    rdx(8'h13, 8'h20);
    $display("test write done");
    // Reset in mid-run clears the active flags and the alarm pin
    res(1, 16'hc000);
    rst_i = 1'b1;
    @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    chk("alarm", 8'h00, {7'h00, alarm});
    rdx(8'h12, 8'h00);
    rdx(8'h14, 8'h00);
    $display("test second reset done");
    end_of_test();
  end
endmodule : tb_top
